//--- hw/scdc_top.sv
`timescale 1ns/1ps
`default_nettype none
module scdc_top
  import scdc_pkg::*;
#(
  parameter logic [SCDC_FB_W-1:0] FB_RESET = SCDC_FB_RST
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic sys_reset_i,
  input wire logic [SCDC_ADDR_W-1:0] addr_i,
  input wire logic [SCDC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [SCDC_DATA_W-1:0] rdata_o,
  input wire logic irq_i,
  input wire logic frc_tick_i,
  output logic instr_tick_o,
  output logic periph_tick_o,
  output logic cpu_tick_o,
  output logic frc_div_tick_o,
  output logic reduction_active_o,
  output logic [SCDC_FB_W:0] pll_m_o,
  output logic [SCDC_PRE_W:0] pll_n1_o,
  output logic [SCDC_POST_W+1:0] pll_n2_o
);
  if (FB_RESET > {SCDC_FB_W{1'b1}})
  begin : g_bad
    $error("scdc_top: FB_RESET too wide");
  end

  // both dividers must reach the largest exponent their codes can select
  if (SCDC_MAX_EXP < SCDC_FRC_TOP_EXP)
  begin : g_bad_frc
    $error("scdc_top: divider too short for the top rc code");
  end

  if (SCDC_MAX_EXP < (1 << SCDC_RATIO_W) - 1)
  begin : g_bad_ratio
    $error("scdc_top: divider too short for the largest ratio");
  end

  // register fields; power-on reset only
  logic recover_on_interrupt_reg;
  logic [SCDC_RATIO_W-1:0] cpu_clock_reduction_ratio_reg;
  logic reduction_enable_reg;
  logic [SCDC_FRC_W-1:0] internal_rc_postscaler_reg;
  logic [SCDC_POST_W-1:0] pll_output_divider_reg;
  logic [SCDC_PRE_W-1:0] pll_input_prescaler_reg;
  logic [SCDC_FB_W-1:0] pll_feedback_multiplier_reg;

  logic [SCDC_RATIO_W-1:0] ratio_next;
  logic enable_next;
  logic fcy_phase_reg;
  logic fcy_tick;

  // decode
  wire wr_div = wr_i && (addr_i == SCDC_CLOCK_DIVISOR_ADDR);
  wire wr_fb = wr_i && (addr_i == SCDC_FEEDBACK_ADDR);
  wire [SCDC_RATIO_W-1:0] wr_ratio = wdata_i[SCDC_RATIO_LSB +: SCDC_RATIO_W];
  wire wr_enable = wdata_i[SCDC_ENABLE_BIT];
  // write-data fields
  wire wr_recover = wdata_i[SCDC_ROI_BIT];
  wire [SCDC_FRC_W-1:0] wr_frc = wdata_i[SCDC_FRC_LSB +: SCDC_FRC_W];
  wire [SCDC_POST_W-1:0] wr_post = wdata_i[SCDC_POST_LSB +: SCDC_POST_W];
  wire [SCDC_PRE_W-1:0] wr_pre = wdata_i[SCDC_PRE_LSB +: SCDC_PRE_W];
  wire [SCDC_FB_W-1:0] wr_fb_val = wdata_i[SCDC_FB_W-1:0];
  // hardware clear of the enable on an interrupt
  wire irq_recover = irq_i && recover_on_interrupt_reg;

  function automatic logic [SCDC_EXP_W-1:0] frc_exp(input logic [SCDC_FRC_W-1:0] code);
    frc_exp = (code == SCDC_FRC_TOP_CODE) ? SCDC_FRC_TOP_EXP : SCDC_EXP_W'(code);
  endfunction

  // ratio field frozen while reduction is on
  assign ratio_next = (wr_div && !reduction_enable_reg) ? wr_ratio : cpu_clock_reduction_ratio_reg;

  // interrupt recovery beats a same-cycle software set
  always_comb
  begin
    enable_next = reduction_enable_reg;
    if (wr_div)
    begin
      enable_next = wr_enable && (ratio_next != SCDC_RATIO_RST);
    end
    if (irq_recover)
    begin
      enable_next = 1'b0;
    end
  end

  wire [SCDC_DATA_W-1:0] div_word = {recover_on_interrupt_reg, cpu_clock_reduction_ratio_reg,
    reduction_enable_reg, internal_rc_postscaler_reg, pll_output_divider_reg, 1'b0,
    pll_input_prescaler_reg};
  wire [SCDC_DATA_W-1:0] fb_word = {{(SCDC_DATA_W-SCDC_FB_W){1'b0}}, pll_feedback_multiplier_reg};
  wire [SCDC_DATA_W-1:0] rd_mux = (addr_i == SCDC_CLOCK_DIVISOR_ADDR) ? div_word :
    (addr_i == SCDC_FEEDBACK_ADDR) ? fb_word : '0;

  // nrst_i is power-on reset; sys_reset_i leaves the register alone
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      recover_on_interrupt_reg <= 1'b0;
      cpu_clock_reduction_ratio_reg <= SCDC_RATIO_RST;
      reduction_enable_reg <= 1'b0;
      internal_rc_postscaler_reg <= SCDC_FRC_RST;
      pll_output_divider_reg <= SCDC_POST_RST;
      pll_input_prescaler_reg <= SCDC_PRE_RST;
      pll_feedback_multiplier_reg <= FB_RESET;
    end
    else if (ce_i)
    begin
      cpu_clock_reduction_ratio_reg <= ratio_next;
      reduction_enable_reg <= enable_next;
      if (wr_div)
      begin
        recover_on_interrupt_reg <= wr_recover;
        internal_rc_postscaler_reg <= wr_frc;
        pll_output_divider_reg <= wr_post;
        pll_input_prescaler_reg <= wr_pre;
      end
      if (wr_fb)
      begin
        pll_feedback_multiplier_reg <= wr_fb_val;
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= '0;
    end
    else if (ce_i)
    begin
      rdata_o <= rd_i ? rd_mux : '0;
    end
  end

  // pll factors; reserved divider code 10 simply yields the formula value
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pll_m_o <= SCDC_M_OFS;
      pll_n1_o <= SCDC_N1_OFS;
      pll_n2_o <= '0;
    end
    else if (ce_i)
    begin
      pll_m_o <= {1'b0, pll_feedback_multiplier_reg} + SCDC_M_OFS;
      pll_n1_o <= {1'b0, pll_input_prescaler_reg} + SCDC_N1_OFS;
      pll_n2_o <= ({2'b00, pll_output_divider_reg} + SCDC_N2_OFS) << 1;
    end
  end

  // instruction tick every second oscillator cycle
  assign fcy_tick = fcy_phase_reg;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fcy_phase_reg <= 1'b0;
      instr_tick_o <= 1'b0;
      periph_tick_o <= 1'b0;
      reduction_active_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (sys_reset_i)
      begin
        fcy_phase_reg <= 1'b0;
        instr_tick_o <= 1'b0;
        periph_tick_o <= 1'b0;
      end
      else
      begin
        fcy_phase_reg <= !fcy_phase_reg;
        instr_tick_o <= fcy_tick;
        periph_tick_o <= fcy_tick;
      end
      reduction_active_o <= reduction_enable_reg;
    end
  end

  // cpu tick: ratio applies only while enabled, else 1:1
  wire [SCDC_EXP_W-1:0] cpu_exp = reduction_enable_reg ? SCDC_EXP_W'(cpu_clock_reduction_ratio_reg) : '0;

  scdc_div #(
    .MAX_EXP(SCDC_MAX_EXP)
  ) u_cpu_div (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .clr_i(sys_reset_i),
    .tick_i(fcy_tick),
    .exp_i(cpu_exp),
    .tick_o(cpu_tick_o)
  );

  wire [SCDC_EXP_W-1:0] frc_exp_sel = frc_exp(internal_rc_postscaler_reg);

  // rc postscaler, code 7 divides by 256
  scdc_div #(
    .MAX_EXP(SCDC_MAX_EXP)
  ) u_frc_div (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .clr_i(sys_reset_i),
    .tick_i(frc_tick_i),
    .exp_i(frc_exp_sel),
    .tick_o(frc_div_tick_o)
  );
endmodule
`default_nettype wire

//--- hw/scdc_pkg.sv
package scdc_pkg;
  localparam int unsigned SCDC_ADDR_W = 4;
  localparam int unsigned SCDC_DATA_W = 16;
  localparam logic [SCDC_ADDR_W-1:0] SCDC_CLOCK_DIVISOR_ADDR = 4'h0;
  localparam logic [SCDC_ADDR_W-1:0] SCDC_FEEDBACK_ADDR = 4'h1;
  // clock divisor field positions
  localparam int unsigned SCDC_ROI_BIT = 15;
  localparam int unsigned SCDC_RATIO_LSB = 12;
  localparam int unsigned SCDC_ENABLE_BIT = 11;
  localparam int unsigned SCDC_FRC_LSB = 8;
  localparam int unsigned SCDC_POST_LSB = 6;
  localparam int unsigned SCDC_PRE_LSB = 0;
  localparam int unsigned SCDC_RATIO_W = 3;
  localparam int unsigned SCDC_FRC_W = 3;
  localparam int unsigned SCDC_POST_W = 2;
  localparam int unsigned SCDC_PRE_W = 5;
  localparam int unsigned SCDC_FB_W = 9;
  localparam int unsigned SCDC_EXP_W = 4;
  localparam int unsigned SCDC_MAX_EXP = 8;
  // reset values
  localparam logic [SCDC_RATIO_W-1:0] SCDC_RATIO_RST = 3'h0;
  localparam logic [SCDC_FRC_W-1:0] SCDC_FRC_RST = 3'h1;
  localparam logic [SCDC_POST_W-1:0] SCDC_POST_RST = 2'h0;
  localparam logic [SCDC_PRE_W-1:0] SCDC_PRE_RST = 5'h00;
  localparam logic [SCDC_FB_W-1:0] SCDC_FB_RST = 9'h000;
  // factor offsets: M = fb + 2, N1 = pre + 2, N2 = 2 * (post + 1)
  localparam logic [SCDC_FB_W:0] SCDC_M_OFS = 10'h002;
  localparam logic [SCDC_PRE_W:0] SCDC_N1_OFS = 6'h02;
  localparam logic [SCDC_POST_W+1:0] SCDC_N2_OFS = 4'h1;
  localparam logic [SCDC_FRC_W-1:0] SCDC_FRC_TOP_CODE = 3'h7;
  localparam logic [SCDC_EXP_W-1:0] SCDC_FRC_TOP_EXP = 4'h8;
endpackage

//--- hw/scdc_div.sv
`timescale 1ns/1ps
`default_nettype none
module scdc_div
  import scdc_pkg::*;
#(
  parameter int unsigned MAX_EXP = SCDC_MAX_EXP
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic tick_i,
  input wire logic [SCDC_EXP_W-1:0] exp_i,
  output logic tick_o
);
  if (MAX_EXP < 1 || MAX_EXP >= (1 << SCDC_EXP_W))
  begin : g_bad
    $error("scdc_div: MAX_EXP out of range");
  end

  logic [MAX_EXP-1:0] cnt_reg;
  logic [MAX_EXP:0] full_span;
  logic [MAX_EXP-1:0] term;
  logic at_term;

  // terminal count is 2^exp - 1, so exp 0 passes every tick through
  assign full_span = (MAX_EXP+1)'(1) << exp_i;
  assign term = MAX_EXP'(full_span - (MAX_EXP+1)'(1));
  assign at_term = (cnt_reg >= term);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (clr_i)
      begin
        cnt_reg <= '0;
        tick_o <= 1'b0;
      end
      else
      begin
        tick_o <= tick_i && at_term;
        if (tick_i)
        begin
          cnt_reg <= at_term ? '0 : cnt_reg + MAX_EXP'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- test/scdc_props.sv
`timescale 1ns/1ps
`default_nettype none
module scdc_props
  import scdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sys_reset_i,
  input wire logic [SCDC_ADDR_W-1:0] addr_i,
  input wire logic [SCDC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic irq_i,
  input wire logic instr_tick_o,
  input wire logic periph_tick_o,
  input wire logic cpu_tick_o,
  input wire logic reduction_active_o,
  input wire logic [SCDC_FB_W:0] pll_m_o,
  input wire logic [SCDC_PRE_W:0] pll_n1_o,
  input wire logic [SCDC_POST_W+1:0] pll_n2_o
);
  logic recover_reg;
  wire logic wr_div = wr_i && addr_i == 4'h0;
  // shadow of the recover bit, so interrupt checks know when they apply
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      recover_reg <= 1'b0;
    else if (wr_div)
      recover_reg <= wdata_i[15];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_instr_half: assert property (instr_tick_o && !sys_reset_i ##1 !sys_reset_i |-> !instr_tick_o ##1 instr_tick_o)
    else $error("instruction tick not every second cycle");
  a_periph_equal: assert property (periph_tick_o == instr_tick_o)
    else $error("peripheral tick differs");
  a_cpu_subset: assert property (cpu_tick_o |-> instr_tick_o)
    else $error("cpu tick off the instruction tick");
  a_cpu_unreduced: assert property (!reduction_active_o [*2] |-> cpu_tick_o == instr_tick_o)
    else $error("cpu tick reduced while disabled");
  a_irq_recover: assert property (irq_i && recover_reg |-> ##2 !reduction_active_o)
    else $error("interrupt left reduction on");
  a_enable_refused: assert property (wr_div && wdata_i[14:12] == 3'h0 ##1 !reduction_active_o |=> !reduction_active_o)
    else $error("enable set with ratio zero");
  a_mult_offset: assert property ($past(wr_i && addr_i == 4'h1, 2) |-> pll_m_o == {1'b0, $past(wdata_i[8:0], 2)} + 10'h002)
    else $error("feedback factor wrong");
  a_pre_offset: assert property ($past(wr_div, 2) |-> pll_n1_o == {1'b0, $past(wdata_i[4:0], 2)} + 6'h02)
    else $error("prescale factor wrong");
  a_post_factor: assert property ($past(wr_div, 2) |-> pll_n2_o == {1'b0, $past(wdata_i[7:6], 2), 1'b0} + 4'h2)
    else $error("postscale factor wrong");
  c_irq: cover property (irq_i && recover_reg);
  c_reduced: cover property (reduction_active_o && cpu_tick_o);
  c_factor: cover property ($past(wr_div, 2));
endmodule
bind scdc_top scdc_props scdc_props_i (.clk_i, .nrst_i, .sys_reset_i, .addr_i, .wdata_i, .wr_i, .irq_i, .instr_tick_o,
  .periph_tick_o, .cpu_tick_o, .reduction_active_o, .pll_m_o, .pll_n1_o, .pll_n2_o);
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 0, nrst_i = 0, sys_reset_i = 0, wr_i = 0, rd_i = 0, irq_i = 0, frc_tick_i = 0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  wire logic [15:0] rdata_o;
  wire logic instr_tick_o, periph_tick_o, cpu_tick_o, frc_div_tick_o, reduction_active_o;
  wire logic [9:0] pll_m_o;
  wire logic [5:0] pll_n1_o;
  wire logic [3:0] pll_n2_o;
  int failures = 0, checks = 0;
  scdc_top scdc_top_i (.clk_i, .nrst_i, .ce_i(1'b1), .sys_reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .irq_i, .frc_tick_i, .instr_tick_o, .periph_tick_o, .cpu_tick_o, .frc_div_tick_o, .reduction_active_o,
    .pll_m_o, .pll_n1_o, .pll_n2_o);
  initial
    forever #12.5 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk("read data", e, rdata_o);
  endtask
  // window lengths are whole periods, so the count does not depend on phase
  task automatic cnt(input int s, input int n, input int e);
    int k;
    k = 0;
    repeat (70) @(negedge clk_i);
    repeat (n)
    begin
      @(negedge clk_i);
      k += (s == 0) ? instr_tick_o : (s == 1) ? cpu_tick_o : frc_div_tick_o;
    end
    chk("tick count", 16'(e), 16'(k));
  endtask
  // one-cycle pulse: s high pulses the system reset, s low the interrupt
  task automatic pulse(input bit s);
    @(posedge clk_i);
    if (s)
      sys_reset_i <= 1'b1;
    else
      irq_i <= 1'b1;
    @(posedge clk_i);
    sys_reset_i <= 1'b0;
    irq_i <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(4'h0, 16'h0100);
    rd(4'h1, 16'h0000);
    rd(4'h5, 16'h0000);
    wr(4'h1, 16'h01ff);
    wr(4'h0, 16'h007f);
    repeat (2) @(negedge clk_i);
    chk("m factor", 16'h0201, {6'h00, pll_m_o});
    chk("n1 factor", 16'h0021, {10'h000, pll_n1_o});
    chk("n2 factor", 16'h0004, {12'h000, pll_n2_o});
    rd(4'h0, 16'h005f);
    cnt(0, 40, 20);
    $display("factor test done");
    for (int r = 1; r < 8; r++)
    begin
      wr(4'h0, 16'(r << 12) | 16'h0800);
      cnt(1, 256, 128 >> r);
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'(r << 12));
    end
    wr(4'h0, 16'h0800);
    rd(4'h0, 16'h0000);
    $display("ratio test done");
    wr(4'h0, 16'h9800);
    pulse(1'b0);
    rd(4'h0, 16'h9000);
    wr(4'h0, 16'h1800);
    pulse(1'b0);
    rd(4'h0, 16'h1800);
    pulse(1'b1);
    rd(4'h0, 16'h1800);
    rd(4'h1, 16'h01ff);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(4'h0, 16'h0100);
    rd(4'h1, 16'h0000);
    $display("recovery test done");
    frc_tick_i <= 1'b1;
    for (int r = 0; r < 8; r++)
    begin
      wr(4'h0, 16'(r << 8));
      cnt(2, 256, (r == 7) ? 1 : 256 >> r);
    end
    $display("divider test done");
    close_out;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    close_out;
  end
endmodule
`default_nettype wire
